// *** logic/cied_pkg.sv ***
// Constants and types of the interrupt enable and dispatch block.
// Assumes a 32-bit APB slave port with a 12-bit byte address.

package cied_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NSRC = 18;
    localparam int AW   = 12;
    localparam int NST  = 4;

    // ****************************************************************
    // Register indices and byte addresses (address = 4 * index)
    // ****************************************************************
    localparam logic [7:0]    IDX_EN_C   = 8'h9a;
    localparam logic [7:0]    IDX_EN_A   = 8'ha8;
    localparam logic [7:0]    IDX_EN_B   = 8'hb8;
    localparam logic [AW-1:0] ADDR_EN_C  = {2'b00, IDX_EN_C, 2'b00};
    localparam logic [AW-1:0] ADDR_EN_A  = {2'b00, IDX_EN_A, 2'b00};
    localparam logic [AW-1:0] ADDR_EN_B  = {2'b00, IDX_EN_B, 2'b00};
    localparam logic [AW-1:0] ADDR_FLAGS = 12'h300;
    localparam logic [AW-1:0] ADDR_PRIO  = 12'h304;
    localparam logic [AW-1:0] ADDR_STAT  = 12'h308;
    localparam logic [AW-1:0] ADDR_MASK  = 12'h30c;
    localparam logic [AW-1:0] ADDR_SVC   = 12'h310;

    // ****************************************************************
    // Field positions, writable masks, reset values
    // ****************************************************************
    localparam int          GIE_BIT   = 7;
    localparam logic [7:0]  EN_A_WMSK = 8'hbf;
    localparam logic [7:0]  EN_BC_WMSK = 8'h3f;
    localparam logic [7:0]  EN_RST    = 8'h00;
    localparam logic [17:0] PRIO_RST  = 18'h00000;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam int          ST_TAKE   = 0;
    localparam int          ST_RET    = 1;
    localparam int          ST_BLOCK  = 2;
    localparam int          ST_BUSERR = 3;

    // Position of each source's enable bit in {en_c, en_b, en_a}
    localparam logic [4:0] EN_POS [NSRC] = '{
        5'd0,  5'd1,  5'd2,  5'd3,  5'd4,  5'd5,  5'd17, 5'd18, 5'd8,
        5'd9,  5'd10, 5'd11, 5'd12, 5'd13, 5'd19, 5'd20, 5'd16, 5'd21};

    // ****************************************************************
    // Vectors and call timing in machine cycles
    // ****************************************************************
    localparam logic [7:0] VEC_BASE    = 8'h03;
    localparam int         VEC_SHIFT   = 3;
    localparam int         CALL_CYCLES = 6;
    localparam logic [2:0] CALL_LOAD   = 3'(CALL_CYCLES - 1);

    typedef enum logic [1:0] {
        CIED_IDLE,
        CIED_DETECT,
        CIED_CALL
    } cied_state_e;

endpackage : cied_pkg

// *** logic/cied_flags.sv ***
// Bank of sticky flags: a set pulse raises a bit, a clear drops it.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module cied_flags
    import cied_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] bits;
    } cied_fl_s;

    cied_fl_s s_reg;
    cied_fl_s s_next;

    // Set wins over a clear in the same cycle
    always_comb begin
        s_next      = s_reg;
        s_next.bits = (s_reg.bits & ~clr_in) | set_in;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.bits;

endmodule : cied_flags

`default_nettype wire

// *** logic/cied_top.sv ***
// Interrupt enable and dispatch: enable registers, request flags,
// priority pick, forced call sequencing and nesting of services.
// Assumes an APB master, same-clock request pulses from peripherals
// and a CPU sequencer that marks instruction boundaries and returns.
// Limitations: two priority levels only; a latched source is called
// even if disabled during its call; eligibility is checked at idle.
// Set wins over clear in both flag banks.
//
// Notes on behaviour
// RULE1 - Cleared master enable blocks every acknowledgement
// RULE2 - Unused enable bits read zero, reset zero
// RULE3 - Group a bits enable six sources
// RULE4 - Group b bits enable six sources
// RULE5 - Group c bits enable six sources
// RULE6 - All enables reset to zero
// RULE7 - Taken interrupt branches to its source vector
// RULE8 - Only strictly higher priority preempts a service
// RULE9 - Return ends service, resumes interrupted code
// RULE10 - Flags set whether or not enabled
// RULE11 - Enabled flag acknowledged next instruction cycle
// RULE12 - Lower or equal requests wait while pending
// RULE13 - Fastest response: detect one, call six
// RULE14 - Eighteen sources, each flag and enable
// RULE15 - Vectors 03h plus eight per source
// RULE16 - Flag cleared by hardware on vectoring
// RULE17 - Pending flag taken once enable is set
`timescale 1ns/100ps
`default_nettype none

module cied_top
    import cied_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            srst,
    // APB slave
    input  wire logic [AW-1:0]   paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Peripheral requests and CPU sequencer
    input  wire logic [NSRC-1:0] irq_src,
    input  wire logic            insn_boundary,
    input  wire logic            return_from_service_exec,
    // Dispatch and nesting state
    output logic                 call_busy,
    output logic      [7:0]      call_vector,
    output logic                 vector_take,
    output logic      [1:0]      service_level,
    output logic      [NSRC-1:0] pending_flags,
    output logic                 irq_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    // The bus answer, enables and nesting live beside the sequencer;
    // flags and status live in banks so set over clear sits in one
    // place.
    typedef struct packed {
        // Software registers
        logic [7:0]      en_a;
        logic [7:0]      en_b;
        logic [7:0]      en_c;
        logic [NSRC-1:0] prio;
        logic [NST-1:0]  mask;
        // Bus answer
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        // Dispatch sequencer
        cied_state_e     st;
        logic [2:0]      cnt;
        logic [4:0]      src;
        logic [7:0]      vec;
        logic            take;
        logic            busy;
        // Nesting and interrupt line
        logic            in_lo;
        logic            in_hi;
        logic            irq;
    } cied_regs_s;

    // Current and next copy of the state
    cied_regs_s s_reg;
    cied_regs_s s_next;

    // Flag and status banks
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] flag_clr;
    logic [NST-1:0]  stat;
    logic [NST-1:0]  stat_set;
    logic [NST-1:0]  stat_clr;
    // Enable mapping and pick
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] cand;
    logic            win_ok;
    logic [4:0]      win_src;
    // Bus strobes and call end
    logic            acc;
    logic            rd_stat;
    logic            wr_flags;
    logic            call_end;
    logic            svc_any;

    // ****************************************************************
    // Request flags and event status
    // ****************************************************************

    // Peripheral pulses raise flags regardless of enables,
    // and a taken call clears its own one
    cied_flags #(
        .W      (NSRC)
    ) u_req_flags (
        .ref_clk (ref_clk),
        .srst    (srst),
        .set_in  (irq_src),                      // [RULE10] [RULE14]
        .clr_in  (flag_clr),
        .q       (flags)
    );

    // Sticky events for the system interrupt line
    // (taken, return, blocked request, bus error)
    cied_flags #(
        .W      (NST)
    ) u_stat_flags (
        .ref_clk (ref_clk),
        .srst    (srst),
        .set_in  (stat_set),
        .clr_in  (stat_clr),
        .q       (stat)
    );

    // Only the edge that sees pready acts, so a master that holds its
    // request longer still writes or clears exactly once.
    // Bus strobes, completed on the edge that sees pready
    assign acc      = psel & penable & s_reg.pready;
    assign rd_stat  = acc & ~pwrite & (paddr == ADDR_STAT);
    assign wr_flags = acc & pwrite & (paddr == ADDR_FLAGS);
    // Last call cycle: flag clear, take event and level update
    assign call_end = (s_reg.st == CIED_CALL) && (s_reg.cnt == 3'h0);
    // Any service level open
    assign svc_any  = s_reg.in_lo | s_reg.in_hi;

    // Hardware clears the taken flag as the call completes
    always_comb begin
        flag_clr = '0;
        if (wr_flags) begin
            flag_clr = pwdata[NSRC-1:0];
        end
        if (call_end) begin
            flag_clr[s_reg.src] = 1'b1;                     // [RULE16]
        end
    end

    // Event sources; a read of the status register clears it
    always_comb begin
        stat_set            = '0;
        stat_set[ST_TAKE]   = call_end;
        stat_set[ST_RET]    = return_from_service_exec & svc_any;
        stat_set[ST_BLOCK]  = |(irq_src & ~src_en);
        stat_set[ST_BUSERR] = acc & s_reg.pslverr;
        stat_clr            = rd_stat ? '1 : '0;
    end

    // ****************************************************************
    // Enable mapping and priority pick
    // ****************************************************************

    // Each source picks its own bit of the three enable groups
    // Unused positions are never mapped, so they enable nothing
    always_comb begin
        logic [23:0] all_en;
        all_en = {s_reg.en_c, s_reg.en_b, s_reg.en_a};
        src_en = '0;
        for (int i = 0; i < NSRC; i++) begin
            src_en[i] = all_en[EN_POS[i]];          // [RULE3] [RULE4] [RULE5]
        end
    end

    // A pending enabled flag competes while the master enable is set;
    // high priority may preempt a low service, nothing preempts high
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            cand[i] = flags[i] & src_en[i]
                      & s_reg.en_a[GIE_BIT]                 // [RULE1] [RULE17]
                      & (s_reg.prio[i] ? ~s_reg.in_hi       // [RULE8]
                                       : ~(s_reg.in_lo | s_reg.in_hi));
        end
    end

    // High level first, then lowest source number
    // A fixed order with no rotation: cheap, but a source that keeps
    // requesting can hold off higher numbers of its own level
    always_comb begin
        logic found;
        found   = 1'b0;
        win_src = 5'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (!found && cand[i] && s_reg.prio[i]) begin
                found   = 1'b1;
                win_src = 5'(i);
            end
        end
        for (int i = 0; i < NSRC; i++) begin
            if (!found && cand[i]) begin
                found   = 1'b1;
                win_src = 5'(i);
            end
        end
        win_ok = found;                                     // [RULE12]
    end

    // ****************************************************************
    // Next state: bus slave, dispatch sequencer, nesting
    // ****************************************************************
    always_comb begin
        s_next         = s_reg;
        s_next.take    = 1'b0;
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;

        // Setup phase: decode and prepare the answer for access phase
        if (psel && !penable) begin
            s_next.pready = 1'b1;
            s_next.prdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_EN_A:  s_next.prdata[7:0] = s_reg.en_a;   // [RULE2]
                ADDR_EN_B:  s_next.prdata[7:0] = s_reg.en_b;
                ADDR_EN_C:  s_next.prdata[7:0] = s_reg.en_c;
                ADDR_FLAGS: s_next.prdata[NSRC-1:0] = flags;
                ADDR_PRIO:  s_next.prdata[NSRC-1:0] = s_reg.prio;
                ADDR_STAT:  s_next.prdata[NST-1:0] = stat;
                ADDR_MASK:  s_next.prdata[NST-1:0] = s_reg.mask;
                ADDR_SVC:   s_next.prdata[15:0] = {s_reg.in_hi,
                                s_reg.in_lo, s_reg.busy, s_reg.src,
                                s_reg.vec};
                default:    s_next.pslverr = 1'b1;
            endcase
        end

        // Access phase write; unused enable bits stay zero
        if (acc && pwrite) begin
            unique case (paddr)
                ADDR_EN_A: s_next.en_a = pwdata[7:0] & EN_A_WMSK; // [RULE2]
                ADDR_EN_B: s_next.en_b = pwdata[7:0] & EN_BC_WMSK;
                ADDR_EN_C: s_next.en_c = pwdata[7:0] & EN_BC_WMSK;
                ADDR_PRIO: s_next.prio = pwdata[NSRC-1:0];
                ADDR_MASK: s_next.mask = pwdata[NST-1:0];
                default:   s_next.prio = s_reg.prio;
            endcase
        end

        // Return ends the innermost active service
        // With no service open it only clears a bit already zero
        if (return_from_service_exec) begin
            if (s_reg.in_hi) begin
                s_next.in_hi = 1'b0;                        // [RULE9]
            end else begin
                s_next.in_lo = 1'b0;                        // [RULE9]
            end
        end

        // Dispatch: one detect cycle, then six call cycles
        unique case (s_reg.st)
            // Latch the winner at an instruction boundary
            CIED_IDLE: begin
                if (win_ok && insn_boundary) begin          // [RULE11]
                    s_next.st   = CIED_DETECT;              // [RULE13]
                    s_next.src  = win_src;
                    s_next.busy = 1'b1;
                    s_next.vec  = VEC_BASE
                                  + {win_src, 3'b000};      // [RULE15]
                end
            end
            // Detect cycle, then load the call counter
            CIED_DETECT: begin
                s_next.st  = CIED_CALL;
                s_next.cnt = CALL_LOAD;                     // [RULE13]
            end
            // Call cycles; take stands in the last one, with busy
            CIED_CALL: begin
                if (s_reg.cnt == 3'h0) begin
                    s_next.st   = CIED_IDLE;
                    s_next.busy = 1'b0;
                    if (s_reg.prio[s_reg.src]) begin
                        s_next.in_hi = 1'b1;
                    end else begin
                        s_next.in_lo = 1'b1;
                    end
                end else begin
                    s_next.cnt  = s_reg.cnt - 3'h1;
                    s_next.take = (s_reg.cnt == 3'h1);      // [RULE7]
                end
            end
            // Unused state code: drop back to idle
            default: begin
                s_next.st   = CIED_IDLE;
                s_next.busy = 1'b0;
            end
        endcase

        // System interrupt line from unmasked sticky events; next status
        // and next mask keep the line in step with the bank
        s_next.irq = |((stat_set | (stat & ~stat_clr)) & s_next.mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            // Enables, levels and sequencer all start cleared
            s_reg         <= '0;
            s_reg.en_a    <= EN_RST;                        // [RULE6]
            s_reg.en_b    <= EN_RST;                        // [RULE6]
            s_reg.en_c    <= EN_RST;                        // [RULE6]
            s_reg.prio    <= PRIO_RST;
            s_reg.mask    <= MASK_RST;
            s_reg.st      <= CIED_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs, each straight from a flip-flop
    // ****************************************************************
    assign prdata        = s_reg.prdata;
    assign pready        = s_reg.pready;
    assign pslverr       = s_reg.pslverr;
    assign call_busy     = s_reg.busy;
    assign call_vector   = s_reg.vec;                       // [RULE7]
    assign vector_take   = s_reg.take;
    // Service level is {high open, low open}
    assign service_level = {s_reg.in_hi, s_reg.in_lo};
    assign pending_flags = flags;
    assign irq_out       = s_reg.irq;

endmodule : cied_top

`default_nettype wire

// *** test/cied_checker.sv ***
// Assertions on dispatch timing and the bus answer of the block.
// Assumes a bind to cied_top; sees only the ports of that module.
`timescale 1ns/100ps
`default_nettype none

module cied_checker
    import cied_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            srst,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic [NSRC-1:0] irq_src,
    input wire logic            insn_boundary,
    input wire logic            return_from_service_exec,
    input wire logic            call_busy,
    input wire logic [7:0]      call_vector,
    input wire logic            vector_take,
    input wire logic [1:0]      service_level,
    input wire logic [NSRC-1:0] pending_flags
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Forced call: seven busy cycles, take pulse in the last one
    sequence s_call;
        call_busy [*7] ##1 !call_busy;
    endsequence
    sequence s_take;
        ##6 vector_take ##1 !vector_take;
    endsequence

    chk_call_len: assert property ($rose(call_busy) |-> s_call)
        else $error("call span not seven cycles");
    chk_take_pos: assert property ($rose(call_busy) |-> s_take)
        else $error("vector take not in last call cycle");
    chk_detect_ok: assert property ($rose(call_busy) |->
        $past(insn_boundary) && !$past(call_busy))
        else $error("call started off an instruction boundary");
    chk_flag_set: assert property ((|irq_src) |=>
        (pending_flags & $past(irq_src)) == $past(irq_src))
        else $error("request flag not set by its source");
    chk_flag_clr: assert property (vector_take && !(|irq_src) |=>
        !pending_flags[$past(call_vector) >> 3])
        else $error("flag left set after vectoring");
    chk_vec_form: assert property (call_busy |->
        call_vector[2:0] == 3'h3 && call_vector <= 8'h8b)
        else $error("vector outside the table");
    chk_hi_nopre: assert property ($rose(call_busy) |->
        !$past(service_level[1]))
        else $error("high level service preempted");
    chk_ret_pop: assert property (return_from_service_exec && service_level == 2'h3 |=>
        service_level == 2'h1)
        else $error("return did not pop the high level");
    chk_take_lvl: assert property (vector_take |=> service_level != 2'h0)
        else $error("no service level after vectoring");
    chk_apb_ans: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
endmodule : cied_checker

bind cied_top cied_checker u_chk (.ref_clk, .srst, .psel, .penable,
    .pready, .irq_src, .insn_boundary, .return_from_service_exec, .call_busy,
    .call_vector, .vector_take, .service_level, .pending_flags);
`default_nettype wire

// *** test/cied_cpu_model.sv ***
// Model of the CPU sequencer: instruction boundaries and returns.
// Assumes the same clock and reset as the interrupt block.
`timescale 1ns/100ps
`default_nettype none

module cied_cpu_model (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic slow,
    input  wire logic ret_req,
    input  wire logic call_busy,
    output logic      insn_boundary,
    output logic      return_from_service_exec
);
    logic [1:0] phase_reg;

    // Slow mode runs four-cycle instructions
    always_ff @(posedge ref_clk) begin
        if (srst) phase_reg <= 2'h0;
        else phase_reg <= slow ? phase_reg + 2'h1 : 2'h0;
    end
    // No boundary while the forced call stalls the CPU
    assign insn_boundary = !call_busy && phase_reg == 2'h0;
    // Return is executed only outside a forced call
    always_ff @(posedge ref_clk) begin
        if (srst) return_from_service_exec <= 1'b0;
        else return_from_service_exec <= ret_req && !call_busy;
    end
endmodule : cied_cpu_model
`default_nettype wire

// *** test/cied_tb_top.sv ***
// Self-checking bench of the interrupt enable and dispatch block.
// Assumes the checker is bound in and the CPU model stands beside.
`timescale 1ns/100ps
`default_nettype none

module cied_tb_top
    import cied_pkg::*;
;
    logic            ref_clk = 1'b0, srst = 1'b1, slow = 1'b0;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0]   paddr = '0;
    logic [31:0]     pwdata = '0, prdata, rd;
    logic            pready, pslverr, insn_boundary, return_from_service_exec;
    logic            call_busy, vector_take, irq_out, ret_req = 1'b0;
    logic [NSRC-1:0] irq_src = '0, pending_flags;
    logic [7:0]      call_vector;
    logic [1:0]      service_level;
    int              err_total = 0, check_count = 0;
    int              en_bit [NSRC] = '{0, 1, 2, 3, 4, 5, 17, 18, 8, 9,
                                       10, 11, 12, 13, 19, 20, 16, 21};

    cied_top dut (.ref_clk, .srst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .irq_src, .insn_boundary,
        .return_from_service_exec, .call_busy, .call_vector, .vector_take,
        .service_level, .pending_flags, .irq_out);
    cied_cpu_model cpu (.ref_clk, .srst, .slow, .ret_req, .call_busy,
        .insn_boundary, .return_from_service_exec);

    // Clock of 5 ns period
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; waits for ready, then releases
    task automatic apb(input logic [AW-1:0] a, input logic w,
                       input logic [31:0] d, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        chk("wait cycles", 1, n);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input int n);
        @(posedge ref_clk);
        irq_src <= NSRC'(1) << n;
        @(posedge ref_clk);
        irq_src <= '0;
    endtask : pulse

    task automatic quiet(input string what);
        logic b;
        b = 1'b0;
        repeat (16) begin
            @(posedge ref_clk);
            b |= (call_busy === 1'b1);
        end
        chk(what, 0, b);
    endtask : quiet

    // Waits for a forced call and measures it
    task automatic take(input int n, input logic [1:0] lvl);
        int w, c, tk;
        w = 0;
        c = 0;
        tk = 0;
        while (call_busy !== 1'b1 && w < 40) begin
            @(posedge ref_clk);
            w++;
        end
        chk("vector", 8'h03 + 8 * n, call_vector);
        while (call_busy === 1'b1 && c < 20) begin
            c++;
            if (vector_take === 1'b1) tk = c;
            @(posedge ref_clk);
        end
        chk("busy span", 7, c);
        chk("take cycle", 7, tk);
        chk("flag cleared", 0, pending_flags[n]);
        chk("level", lvl, service_level);
    endtask : take

    task automatic ret(input logic [1:0] lvl);
        @(posedge ref_clk);
        ret_req <= 1'b1;
        @(posedge ref_clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("level after return", lvl, service_level);
    endtask : ret

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        logic          e;
        logic [AW-1:0] ad [3] = '{ADDR_EN_A, ADDR_EN_B, ADDR_EN_C};
        logic [31:0]   wm [3] = '{32'hbf, 32'h3f, 32'h3f};
        for (int i = 0; i < 3; i++) begin
            apb(ad[i], 1'b0, 32'h0, e);
            chk("enable reset", 0, rd);
            apb(ad[i], 1'b1, 32'hff, e);
            apb(ad[i], 1'b0, 32'h0, e);
            chk("enable bits", wm[i], rd);
            apb(ad[i], 1'b1, 32'h0, e);
        end
        apb(12'h004, 1'b0, 32'h0, e);
        chk("unmapped error", 1, e);
    endtask : t_regs

    // Flag pends while master enable is off, taken once it is set
    task automatic t_gate();
        logic e;
        apb(ADDR_EN_A, 1'b1, 32'h3f, e);
        pulse(4);
        quiet("no call without master");
        chk("flag while off", 1, pending_flags[4]);
        pulse(5);
        apb(ADDR_FLAGS, 1'b1, 32'h20, e);
        @(posedge ref_clk);
        chk("flag write clear", 0, pending_flags[5]);
        apb(ADDR_EN_A, 1'b1, 32'hbf, e);
        take(4, 2'h1);
        ret(2'h0);
    endtask : t_gate

    // Each source alone through its own enable bit
    task automatic t_each();
        logic        e;
        logic [23:0] en;
        for (int n = 0; n < NSRC; n++) begin
            en = 24'h80 | (24'h1 << en_bit[n]);
            apb(ADDR_EN_A, 1'b1, {24'h0, en[7:0]}, e);
            apb(ADDR_EN_B, 1'b1, {24'h0, en[15:8]}, e);
            apb(ADDR_EN_C, 1'b1, {24'h0, en[23:16]}, e);
            pulse(n);
            take(n, 2'h1);
            ret(2'h0);
        end
        chk("irq masked", 0, irq_out);
    endtask : t_each

    // Nesting by level with slow instructions
    task automatic t_nest();
        logic e;
        slow <= 1'b1;
        apb(ADDR_EN_A, 1'b1, 32'hbf, e);
        apb(ADDR_EN_B, 1'b1, 32'h3f, e);
        apb(ADDR_EN_C, 1'b1, 32'h3f, e);
        apb(ADDR_PRIO, 1'b1, 32'h200, e);
        apb(ADDR_MASK, 1'b1, 32'h1, e);
        pulse(3);
        take(3, 2'h1);
        pulse(1);
        quiet("equal level waits");
        pulse(9);
        take(9, 2'h3);
        ret(2'h1);
        quiet("still pending");
        chk("pending flag", 1, pending_flags[1]);
        ret(2'h0);
        take(1, 2'h1);
        ret(2'h0);
        chk("irq raised", 1, irq_out);
        apb(ADDR_STAT, 1'b0, 32'h0, e);
        chk("status taken", 1, rd[ST_TAKE]);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 0, irq_out);
    endtask : t_nest

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_gate();
        t_each();
        t_nest();
        finish_test();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule : cied_tb_top
`default_nettype wire
